// ==== inc/flash_host_pkg.sv ====
// Purpose: constants and carriers for the flash host controller
// Assumes: mclk at 125 MHz
// Notes: register offsets are byte addresses on the AHB-Lite slave
package flash_host_pkg;
  localparam int CLK_MHZ = 125;
  localparam int RESET_PULSE_NS = 500;
  localparam int WAKE_NS = 500;
  localparam int READY_US = 20;
  localparam int RESET_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int READY_CYC = READY_US * CLK_MHZ;
  localparam int STROBE_CYC = 8;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC);
  localparam logic [CNT_W-1:0] RESET_CNT = CNT_W'(RESET_CYC);
  localparam logic [CNT_W-1:0] WAKE_CNT = CNT_W'(WAKE_CYC);
  localparam logic [CNT_W-1:0] READY_CNT = CNT_W'(READY_CYC);
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam int CMD_WRITE = 0;
  localparam int CMD_READ = 1;
  localparam int CMD_RESET = 2;
  localparam int CMD_POLL = 3;
  localparam int BIT_SEC_TOG = 2;
  localparam int BIT_WIN = 3;
  localparam int BIT_TMO = 5;
  localparam int BIT_PRI_TOG = 6;
  localparam int BIT_CPOLL = 7;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic reset_n;
    logic [20:0] addr;
    logic [7:0] dq_out;
    logic dq_oe;
  } flash_pins_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WR = 3'b001,
    ST_RD = 3'b010,
    ST_RD2 = 3'b011,
    ST_RST = 3'b100,
    ST_WAKE = 3'b101
  } host_state_t;
endpackage : flash_host_pkg

// ==== hdl/flash_host.sv ====
// Purpose: AHB-Lite controlled host that drives a parallel NOR flash through its pins
// Assumes: flash pins are asynchronous; inputs are synchronised by two flops
// Notes: status bits are captured per read; toggle detection uses two reads
module flash_host (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output flash_host_pkg::flash_pins_t pins,
  input wire logic [7:0] dq_in,
  input wire logic ready_busy_n
);
  import flash_host_pkg::*;

  host_state_t state_ff, nxt_state;
  flash_pins_t pins_ff, nxt_pins;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [7:0] rd1_ff, nxt_rd1, rd2_ff, nxt_rd2;
  logic poll_ff, nxt_poll, done_ff, nxt_done, fail_ff, nxt_fail, second_ff, nxt_second;
  logic [20:0] addr_ff, nxt_addr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic [7:0] dq_s1_ff, dq_s2_ff;
  logic rb_s1_ff, rb_s2_ff;
  logic [7:0] ap_addr_ff;
  logic ap_wr_ff, ap_valid_ff;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic busy;

  // two-flop synchronisers for the flash pins
  always_ff @(posedge mclk) begin
    dq_s1_ff <= dq_in;
    dq_s2_ff <= dq_s1_ff;
    rb_s1_ff <= ready_busy_n;
    rb_s2_ff <= rb_s1_ff;
  end

  // ahb address phase capture; slave never stalls
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ap_addr_ff <= 8'h00;
      ap_wr_ff <= 1'b0;
      ap_valid_ff <= 1'b0;
    end else if (hready) begin
      ap_addr_ff <= haddr[7:0];
      ap_wr_ff <= hwrite;
      ap_valid_ff <= hsel && htrans[1];
    end
  end

  assign busy = (state_ff != ST_IDLE);

  always_comb begin
    nxt_state = state_ff;
    nxt_pins = pins_ff;
    nxt_cnt = cnt_ff;
    nxt_rd1 = rd1_ff;
    nxt_rd2 = rd2_ff;
    nxt_poll = poll_ff;
    nxt_done = done_ff;
    nxt_fail = fail_ff;
    nxt_second = second_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_hrdata = hrdata_ff;
    // read data is fetched in the address phase so it stands through the data phase
    if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        OFS_ADDR: nxt_hrdata = {11'h000, addr_ff};
        OFS_DATA: nxt_hrdata = {24'h000000, wdata_ff};
        OFS_STAT: nxt_hrdata = {26'h0000000, fail_ff, done_ff, ~rb_s2_ff, busy, 2'h0};
        OFS_RDATA: nxt_hrdata = {16'h0000, rd2_ff, rd1_ff};
        default: nxt_hrdata = 32'h00000000;
      endcase
    end
    if (ap_valid_ff && ap_wr_ff) begin
      if (ap_addr_ff == OFS_ADDR) begin
        nxt_addr = hwdata[20:0];
      end
      if (ap_addr_ff == OFS_DATA) begin
        nxt_wdata = hwdata[7:0];
      end
    end
    case (state_ff)
      ST_IDLE: begin
        if (ap_valid_ff && ap_wr_ff && ap_addr_ff == OFS_CMD) begin
          nxt_done = 1'b0;
          nxt_fail = 1'b0;
          nxt_pins.addr = addr_ff;
          nxt_cnt = STROBE_CNT;
          if (hwdata[CMD_WRITE]) begin
            // write: ce and we low, oe high, data driven
            nxt_pins.ce_n = 1'b0;
            nxt_pins.we_n = 1'b0;
            nxt_pins.oe_n = 1'b1;
            nxt_pins.dq_out = wdata_ff;
            nxt_pins.dq_oe = 1'b1;
            nxt_state = ST_WR;
          end else if (hwdata[CMD_READ] || hwdata[CMD_POLL]) begin
            nxt_poll = hwdata[CMD_POLL];
            nxt_second = 1'b0;
            nxt_pins.ce_n = 1'b0;
            nxt_pins.oe_n = 1'b0;
            nxt_state = ST_RD;
          end else if (hwdata[CMD_RESET]) begin
            nxt_pins.reset_n = 1'b0;
            nxt_pins.dq_oe = 1'b0;
            nxt_cnt = RESET_CNT;
            nxt_state = ST_RST;
          end
        end
      end
      ST_WR: begin
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff == '0 && !pins_ff.we_n) begin
          // write strobe rises alone so the flash latches while chip select is still low
          nxt_pins.we_n = 1'b1;
          nxt_cnt = '0;
        end else if (cnt_ff == '0) begin
          nxt_pins.ce_n = 1'b1;
          nxt_pins.dq_oe = 1'b0;
          nxt_done = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_RD, ST_RD2: begin
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff == '0) begin
          nxt_pins.oe_n = 1'b1;
          nxt_pins.ce_n = 1'b1;
          nxt_cnt = STROBE_CNT;
          if (state_ff == ST_RD) begin
            // a plain read hands software the erase window flag for its before/after check
            nxt_rd1 = dq_s2_ff;
            nxt_state = poll_ff ? ST_RD2 : ST_IDLE;
            nxt_done = !poll_ff;
          end else begin
            // second read of pair: compare primary toggle bit
            nxt_rd2 = dq_s2_ff;
            if (rd1_ff[BIT_PRI_TOG] == dq_s2_ff[BIT_PRI_TOG]) begin
              nxt_done = 1'b1;
              nxt_state = ST_IDLE;
            end else if (second_ff) begin
              // timeout seen last time and still toggling: failure
              nxt_fail = 1'b1;
              nxt_done = 1'b1;
              nxt_state = ST_IDLE;
            end else begin
              nxt_second = dq_s2_ff[BIT_TMO];
              nxt_rd1 = dq_s2_ff;
              nxt_state = ST_RD2;
            end
          end
        end else if (cnt_ff == STROBE_CNT && pins_ff.oe_n) begin
          nxt_pins.ce_n = 1'b0;
          nxt_pins.oe_n = 1'b0;
        end
      end
      ST_RST: begin
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff == '0) begin
          nxt_pins.reset_n = 1'b1;
          nxt_cnt = WAKE_CNT;
          nxt_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff == '0) begin
          nxt_done = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      pins_ff <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, reset_n: 1'b1,
                   addr: 21'h000000, dq_out: 8'h00, dq_oe: 1'b0};
      cnt_ff <= '0;
      rd1_ff <= 8'h00;
      rd2_ff <= 8'h00;
      poll_ff <= 1'b0;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
      second_ff <= 1'b0;
      addr_ff <= 21'h000000;
      wdata_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      pins_ff <= nxt_pins;
      cnt_ff <= nxt_cnt;
      rd1_ff <= nxt_rd1;
      rd2_ff <= nxt_rd2;
      poll_ff <= nxt_poll;
      done_ff <= nxt_done;
      fail_ff <= nxt_fail;
      second_ff <= nxt_second;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      hrdata_ff <= nxt_hrdata;
    end
  end

  assign pins = pins_ff;
  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  AST_WRITE_QUAL: assert property (@(posedge mclk) disable iff (!rst_n)
    !pins_ff.we_n |-> (!pins_ff.ce_n && pins_ff.oe_n && pins_ff.dq_oe))
    else $error("write strobe low without proper qualifiers");
  AST_RESET_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(pins_ff.reset_n) |-> !pins_ff.reset_n [*8])
    else $error("reset pulse too short");
  AST_RESET_NODRV: assert property (@(posedge mclk) disable iff (!rst_n)
    !pins_ff.reset_n |-> !pins_ff.dq_oe && pins_ff.oe_n)
    else $error("bus driven during flash reset");
  AST_WAKE_DONE: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(pins_ff.reset_n) |-> !done_ff [*8])
    else $error("done before wake time");
  AST_FAIL_REREAD: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(fail_ff) |-> $past(second_ff))
    else $error("failure without reread after timeout");
  AST_NO_OVERLAP: assert property (@(posedge mclk) disable iff (!rst_n)
    !(!pins_ff.oe_n && !pins_ff.we_n))
    else $error("read and write strobes overlap");
  AST_TOGGLE_STOP: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_ff == ST_RD2 && cnt_ff == '0 && rd1_ff[BIT_PRI_TOG] == dq_s2_ff[BIT_PRI_TOG])
    |=> done_ff && state_ff == ST_IDLE)
    else $error("steady toggle bit not taken as completion");
  AST_IDLE_PINS: assert property (@(posedge mclk) disable iff (!rst_n)
    state_ff == ST_IDLE |-> pins_ff.ce_n && pins_ff.we_n && pins_ff.oe_n)
    else $error("strobes active while idle");
endmodule : flash_host

// ==== bench/flash_model.sv ====
// Purpose: behavioural parallel flash that answers the host pins
// Assumes: program, sector erase and erase suspend; busy times shortened by parameters
// Notes: released data lines show the inverse of the last value
module flash_model #(
  parameter int BUSY_NS = 2000,
  parameter int ERASE_NS = 20000,
  parameter int SECT_LSB = 16,
  parameter logic [23:0] UNLOCK = 24'hAA55A0,
  parameter logic [47:0] ERASE_SEQ = 48'hAA5580AA5530,
  parameter logic [7:0] SUSPEND = 8'hB0
) (
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic reset_n,
  input wire logic [20:0] addr,
  input wire logic [7:0] din,
  output logic [7:0] dout,
  output wire logic ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [logic [20:0]];
  logic [7:0] pdat = 8'h00;
  logic [20:0] pa = 21'h0;
  logic busy = 1'b0;
  logic lock = 1'b0;
  logic tog = 1'b0;
  logic tog2 = 1'b0;
  logic ers = 1'b0;
  logic susp = 1'b0;
  logic pwr_armed = 1'b1;
  logic [47:0] sq = 48'h000000000000;
  logic [20:0] sect = 21'h000000;
  realtime up = 0;
  wire rd = !oe_n && !ce_n && reset_n;
  assign ready_busy_n = !(busy || ers || !reset_n);
  initial dout = 8'h00; // read mode from power-up
  always @(posedge we_n) begin
    if (pwr_armed) begin
      pwr_armed = 1'b0; // first rising write strobe after power-up takes no command
    end else if (!ce_n && oe_n && reset_n && !busy) begin
      if (ers) begin
        // only the suspend command is taken while an erase runs
        if (din == SUSPEND) begin
          ers = 1'b0;
          susp = 1'b1;
        end
      end else begin
        sq = {sq[39:0], din};
        if (sq[31:8] == UNLOCK) begin
          pa = addr;
          pdat = din;
          lock = mem.exists(addr) && ((din & ~mem[addr]) != 8'h00);
          sq = 48'h000000000000;
          busy = 1'b1;
        end else if (sq == ERASE_SEQ) begin
          sect = addr >> SECT_LSB;
          susp = 1'b0;
          sq = 48'h000000000000;
          ers = 1'b1;
        end
      end
    end
  end
  always @(posedge ers) begin
    #(ERASE_NS);
    ers = 1'b0; // sector contents after an erase are not modelled
  end
  always @(posedge busy) begin
    #(BUSY_NS);
    if (busy && !lock) begin
      mem[pa] = pdat;
      busy = 1'b0;
    end
  end
  always @(negedge reset_n) begin
    if (busy) mem[pa] = ~pdat;
    busy = 1'b0;
    lock = 1'b0;
    ers = 1'b0;
    susp = 1'b0;
    sq = 48'h000000000000;
  end
  always @(posedge reset_n) up = $realtime;
  always @(rd) begin
    if (rd && busy) begin
      tog = ~tog;
      dout = {~pdat[7], tog, lock, 5'h00};
    end else if (rd && ers) begin
      tog = ~tog;
      if ((addr >> SECT_LSB) == sect) tog2 = ~tog2; // only the erasing sector
      dout = {1'b0, tog, 2'b00, 1'b1, tog2, 2'b00};
    end else if (rd && susp && (addr >> SECT_LSB) == sect) begin
      tog2 = ~tog2; // primary steady, secondary toggling
      dout = {2'b11, 2'b00, 1'b1, tog2, 2'b00};
    end else if (rd && ($realtime - up) >= 500) begin
      dout = mem.exists(addr) ? mem[addr] : 8'hFF;
    end else begin
      dout = ~dout;
    end
  end
endmodule : flash_model

// ==== bench/test_flash_status_reset_protect.sv ====
// Purpose: self-checking bench for the flash host controller
// Assumes: flash model on the pins, single AHB-Lite master
// Notes: expected results are queued and compared by a separate watcher
module test_flash_status_reset_protect;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_host_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  flash_pins_t pins;
  logic [7:0] fdq;
  wire ready_busy_n;
  logic [63:0] q[$];
  logic [31:0] got = 32'h0;
  logic got_v = 1'b0;
  logic [20:0] a;
  logic [7:0] d;
  logic [31:0] r1;
  int fails = 0;
  int total_checks = 0;
  int rlo = 0;
  int bad = 0;
  int n;
  always #4 mclk = ~mclk;
  flash_host DUT (.mclk(mclk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .pins(pins),
    .dq_in(pins.dq_oe ? pins.dq_out : fdq), .ready_busy_n(ready_busy_n));
  flash_model FM (.ce_n(pins.ce_n), .we_n(pins.we_n), .oe_n(pins.oe_n),
    .reset_n(pins.reset_n), .addr(pins.addr), .din(pins.dq_out), .dout(fdq),
    .ready_busy_n(ready_busy_n));
  task automatic finish_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  task automatic cmp(input logic [31:0] g);
    logic [63:0] e;
    e = q.pop_front();
    total_checks++;
    if ((g & e[31:0]) !== (e[63:32] & e[31:0])) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, g & e[31:0], e[63:32] & e[31:0]);
    end
  endtask : cmp
  always @(posedge mclk) begin
    if (!pins.reset_n) rlo <= rlo + 1;
    if (rst_n && !pins.we_n && (pins.ce_n || !pins.oe_n)) bad <= bad + 1;
    if (got_v) cmp(got);
  end
  task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    haddr <= {24'h0, ad};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    got = hrdata;
  endtask : ahb
  task automatic post(input logic [31:0] e, input logic [31:0] m, input logic [31:0] g);
    q.push_back({e, m});
    got = g;
    got_v <= 1'b1;
    @(posedge mclk);
    got_v <= 1'b0;
    @(posedge mclk);
  endtask : post
  task automatic expect_rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
    ahb(1'b0, ad, 32'h0);
    post(e, m, got);
  endtask : expect_rd
  task automatic cmd(input int b);
    ahb(1'b1, OFS_CMD, 32'h1 << b);
    n = 0;
    do begin
      ahb(1'b0, OFS_STAT, 32'h0);
      n++;
    end while (got[2] !== 1'b0 && n < 500);
    if (n >= 500) fails++;
  endtask : cmd
  task automatic fw(input logic [20:0] fa, input logic [7:0] fd);
    ahb(1'b1, OFS_ADDR, {11'h0, fa});
    ahb(1'b1, OFS_DATA, {24'h0, fd});
    cmd(CMD_WRITE);
  endtask : fw
  task automatic prog(input logic [20:0] pa, input logic [7:0] pd);
    fw(21'h555, 8'hAA);
    fw(21'h2AA, 8'h55);
    fw(21'h555, 8'hA0);
    fw(pa, pd);
  endtask : prog
  task automatic erase(input logic [20:0] sa);
    fw(21'h555, 8'hAA);
    fw(21'h2AA, 8'h55);
    fw(21'h555, 8'h80);
    fw(21'h555, 8'hAA);
    fw(21'h2AA, 8'h55);
    fw(sa, 8'h30);
  endtask : erase
  initial begin
    #200us;
    fails++;
    finish_test();
  end
  initial begin
    n = $urandom(32'hFF5AB100);
    a = 21'($urandom);
    d = 8'($urandom) & 8'hFE;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    expect_rd(OFS_STAT, 32'h0, 32'h8);
    prog(a, d);
    expect_rd(OFS_STAT, 32'h8, 32'h8);
    cmd(CMD_POLL);
    expect_rd(OFS_STAT, 32'h0, 32'h20);
    cmd(CMD_READ);
    expect_rd(OFS_RDATA, {24'h0, d}, 32'hFF);
    prog(a, d | 8'h01);
    cmd(CMD_POLL);
    expect_rd(OFS_STAT, 32'h20, 32'h20);
    cmd(CMD_RESET);
    post(32'h1, 32'h1, 32'(rlo >= RESET_CYC));
    ahb(1'b1, OFS_ADDR, {11'h0, ~a});
    cmd(CMD_READ);
    expect_rd(OFS_RDATA, 32'hFF, 32'hFF);
    erase(a);
    expect_rd(OFS_STAT, 32'h8, 32'h8);
    ahb(1'b1, OFS_ADDR, {11'h0, a});
    cmd(CMD_READ);
    ahb(1'b0, OFS_RDATA, 32'h0);
    r1 = got;
    cmd(CMD_READ);
    ahb(1'b0, OFS_RDATA, 32'h0);
    post(32'h44, 32'h44, got ^ r1);
    ahb(1'b1, OFS_ADDR, {11'h0, a ^ 21'h100000});
    cmd(CMD_READ);
    ahb(1'b0, OFS_RDATA, 32'h0);
    r1 = got;
    cmd(CMD_READ);
    ahb(1'b0, OFS_RDATA, 32'h0);
    post(32'h40, 32'h44, got ^ r1);
    fw(a, 8'hB0);
    expect_rd(OFS_STAT, 32'h0, 32'h8);
    cmd(CMD_POLL);
    ahb(1'b0, OFS_RDATA, 32'h0);
    post(32'h04, 32'h44, got ^ (got >> 8));
    cmd(CMD_RESET);
    expect_rd(OFS_STAT, 32'h10, 32'h18);
    post(32'h0, 32'hFFFFFFFF, 32'(bad));
    finish_test();
  end
endmodule : test_flash_status_reset_protect
